// ---- bench/device_model.sv ----
`timescale 1ns/1ns
// attached device: meets the selected condition on command (010 drops dp_above_th, raises dp_above_floor), the
// comparators it is not asked about wander every cycle
module device_model (
  // clock
  input  wire logic                  clk,
  // scenario control
  input  wire logic                  active,
  input  wire logic [2:0]            sel,
  // comparator levels
  output stim_one_pkg::stim_inputs_t stim_in
);
  stim_one_pkg::stim_inputs_t s;
  logic [4:0]                 nz;

  always @(negedge clk) begin
    nz = 5'($urandom);
    s = nz;
    case (sel)
      3'h0: s.vbus_ready_pre = active;
      3'h7: s.vbus_present_post = active;
      3'h1, 3'h6: s.dp_above_th = active;
      3'h3: s.dm_above_th = active;
      3'h2: begin
        s.dp_above_th = active ? 1'b0 : nz[0];
        s.dp_above_floor = active ? 1'b1 : nz[0];
      end
      default: s = nz;
    endcase
    stim_in <= s;
  end
endmodule

// ---- bench/tb_custom_emulation_stimulus_one.sv ----
`timescale 1ns/1ns
module tb_custom_emulation_stimulus_one;
  localparam int CPM = 4;
  logic                       clk        = 1'b0;
  logic                       rst        = 1'b1;
  logic [7:0]                 reg_addr   = 8'h00;
  logic                       reg_wr     = 1'b0;
  logic [7:0]                 reg_wdata  = 8'h00;
  logic                       reg_rd     = 1'b0;
  logic [7:0]                 reg_rdata;
  stim_one_pkg::stim_inputs_t stim_in;
  stim_one_pkg::line_drive_t  line_drive;
  logic                       step_done;
  logic                       active     = 1'b0;
  logic [2:0]                 msel       = 3'h0;
  stim_one_pkg::line_drive_t  pd;
  int                         err_total  = 0;
  int                         num_checks = 0;
  int                         cyc        = 0;
  int                         regm [3]   = '{0, 0, 0};
  int                         tms [8]    = '{0, 1, 5, 10, 20, 40, 80, 100};
  int                         sels [6]   = '{0, 1, 2, 3, 6, 7};
  int                         defs [16]  = '{0, 1, 2, 3, 4, 6, 7, 9, 10, 12, 13, 14, 15, 14, 15, 12};
  int                         dir [8]    = '{'h41B9, 'h41EC, 'h4145, 'h4271, 'h42F2, 'h4235,
                                             'h4248, 'h429B};

  custom_emulation_stimulus_one #(.CYC_PER_MS(CPM)) custom_emulation_stimulus_one_i (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .stim_in(stim_in), .line_drive(line_drive),
    .step_done(step_done)
  );

  device_model device_model_i (.clk(clk), .active(active), .sel(msel), .stim_in(stim_in));

  always #10 clk = ~clk;

  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      complete_run();
    end
  end

  task automatic complete_run();
    if (err_total == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic chkd(input stim_one_pkg::line_drive_t exp, input string m);
    num_checks++;
    if (line_drive !== exp) begin
      err_total++;
      $display("BAD %0t %s got %h exp %h", $time, m, line_drive, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    @(negedge clk);
    chk8(reg_rdata, e, "register read");
  endtask

  // register image after a write, reserved codes refused per field
  function automatic int model_wr(input int a, input int o, input int d);
    int r;
    r = d;
    if (a == 1) begin
      r = d & 'h7F;
      if ((d & 7) == 4 || (d & 7) == 5) r = (r & 'h78) | (o & 7);
    end
    if (a == 2) begin
      if ((d >> 4) == 15) r = (o & 'hF0) | (d & 15);
      if ((d & 15) == 5 || (d & 15) == 8 || (d & 15) == 11) r = (r & 'hF0) | (o & 15);
    end
    return r;
  endfunction

  function automatic stim_one_pkg::line_drive_t exp_drv(input int df, input int mg, input int sl);
    stim_one_pkg::line_drive_t e;
    logic                      k;
    k = (sl == 0);
    e = '0;
    e.magnitude = 4'(mg);
    case (df)
      0: e = '0;
      1: begin e.dp_volt = 1'b1; e.dm_pulldown = k; end
      2: begin e.dm_volt = 1'b1; e.dp_pulldown = k; end
      3: begin e.dp_volt = 1'b1; e.dm_volt = 1'b1; end
      4: begin e.dp_res = 1'b1; e.dm_pulldown = k; end
      6: begin e.dp_div = 1'b1; e.dm_pulldown = k; end
      7: begin e.dm_res = 1'b1; e.dp_pulldown = k; end
      9: begin e.dm_div = 1'b1; e.dp_pulldown = k; end
      10: begin e.short_lines = 1'b1; e.dp_pulldown = k; e.dm_pulldown = k; end
      12: begin e.dp_div = 1'b1; e.dm_div = 1'b1; end
      13: begin e.dp_res = 1'b1; e.dm_res = 1'b1; end
      default: e = (sl == 7) ? '0 : pd;
    endcase
    return e;
  endfunction

  task automatic run_case(input int ty, input int td, input int sl, input int df, input bit ab);
    stim_one_pkg::line_drive_t e;
    int                        n;
    int                        lim;
    int                        mg;
    mg = $urandom_range(0, 14);
    n = 0;
    e = exp_drv(df, mg, sl);
    lim = tms[td] * CPM;
    wr(8'h41, 8'((ty << 6) | (td << 3) | sl));
    wr(8'h42, 8'((mg << 4) | df));
    wr(8'h40, 8'h01);
    @(posedge clk);
    msel = 3'(sl);
    repeat (3) @(negedge clk);
    chkd(pd, "lines before stimulus");
    chk8({7'h00, step_done}, 8'h00, "done before stimulus");
    @(posedge clk);
    active = 1'b1;
    if (ab) begin
      repeat (20) @(negedge clk);
      chkd(pd, "lines during delay");
      chk8({7'h00, step_done}, 8'h00, "done during delay");
    end else if (ty == 1) begin
      while (line_drive === pd && n < 10) begin
        @(negedge clk);
        n++;
      end
      chkd(e, "hold applied");
      repeat (lim + 10) @(negedge clk);
      chkd((sl == 0 || sl == 7) ? pd : e, "hold with stimulus");
      @(posedge clk);
      active = 1'b0;
      repeat (4) @(negedge clk);
      chkd(pd, "hold removed");
    end else begin
      while (step_done !== 1'b1 && n < lim + 40) begin
        @(negedge clk);
        n++;
      end
      chk8(8'(n + CPM >= lim + 3 && n <= lim + CPM + 8), 8'h01, "delay length");
      chkd(e, "delayed response");
    end
    if (!ab) begin
      n = 0;
      while (step_done !== 1'b1 && n < 40) begin
        @(negedge clk);
        n++;
      end
      chk8({7'h00, step_done}, 8'h01, "step finished");
    end
    wr(8'h40, 8'h00);
    @(posedge clk);
    active = 1'b0;
    repeat (2) @(negedge clk);
    chkd('0, "run cleared");
    chk8({7'h00, step_done}, 8'h00, "done after clear");
  endtask

  initial begin
    int a;
    int d;
    pd = '0;
    pd.dp_pulldown = 1'b1;
    pd.dm_pulldown = 1'b1;
    void'($urandom(74));
    repeat (10) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 4; i++) begin
      rd(8'(8'h40 + i), 8'h00);
    end
    for (int i = 0; i < 32; i++) begin
      a = (i < 8) ? (dir[i] >> 8) - 'h40 : $urandom_range(0, 3);
      d = (i < 8) ? dir[i] & 'hFF : $urandom_range(0, 255);
      wr(8'(a + 'h40), 8'(d));
      if (a < 3) regm[a] = model_wr(a, regm[a], d);
      rd(8'(a + 'h40), (a < 3) ? 8'(regm[a]) : 8'h00);
    end
    // random writes may have started a run: stop it so each case starts from idle
    wr(8'h40, 8'h00);
    wr(8'h42, 8'h00);
    for (int i = 0; i < 16; i++) begin
      run_case(0, i % 8, sels[i % 6], defs[i], 1'b0);
    end
    run_case(1, 1, 1, 7, 1'b0);
    run_case(1, 1, 7, 13, 1'b0);
    run_case(1, 0, 0, 2, 1'b0);
    run_case(0, 7, 3, 1, 1'b1);
    // reset in mid-run clears lines and registers
    wr(8'h40, 8'h01);
    repeat (3) @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    chkd('0, "lines after reset");
    rd(8'h41, 8'h00);
    complete_run();
  end
endmodule

// ---- core/custom_emulation_stimulus_one.sv ----
// Behaviour
// - Bit 7 of the timing and selection register always reads zero.
// - Timer behaviour one: apply at once, hold for timer, then remove once stimulus gone; 000 and 111 remove at timer end.
// - Timer behaviour zero: timer is a delay from detection to applying the response.
// - Timer code decodes to 0, 1, 5, 10, 20, 40, 80, 100 ms.
// - Selection 000: bus power ready before switch; next step does not wait.
// - Selections 001 and 110 watch positive line, 011 negative line, above threshold.
// - Selection 010: positive line below threshold and above fixed 400 mV floor.
// - Selection 111: bus power after switch; 100 and 101 must not be written.
// - Writes of reserved codes are refused; the field keeps its old value.
// - Voltage responses use the magnitude as a voltage to ground.
// - Resistor responses use the magnitude as a resistor value.
// - Divider responses use the magnitude as minimum total divider resistance.
// - Codes 0000 clear both lines; 0001-0011 drive voltage on positive, negative, both.
// - Codes 0100, 0111, 1101 resistor to ground; 1010 low resistance between lines.
// - Codes 0110, 1001, 1100 divider on positive, negative, both; 0101, 1000, 1011 avoided.
// - Codes 1110/1111 keep pull-downs for 000, remove for 111, else no change.
// - Single-line response with 000 keeps other line's pull-down, else drops it.
`timescale 1ns/1ns
`include "stim_one_consts.svh"

module custom_emulation_stimulus_one #(
  parameter int CYC_PER_MS = `MS_PERIOD_NS / `CLK_PERIOD_NS
) (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst,
  // register port
  input  wire logic [7:0]                 reg_addr,
  input  wire logic                       reg_wr,
  input  wire logic [7:0]                 reg_wdata,
  input  wire logic                       reg_rd,
  output logic      [7:0]                 reg_rdata,
  // stimulus comparators
  input  wire stim_one_pkg::stim_inputs_t stim_in,
  // data line response and sequencing
  output stim_one_pkg::line_drive_t       line_drive,
  output logic                            step_done
);

  logic [7:0]                cfg_q,    cfg_d;
  logic [6:0]                timing_q, timing_d;
  logic [7:0]                resp_q,   resp_d;
  logic [7:0]                rdata_q,  rdata_d;
  stim_one_pkg::state_t      state_q,  state_d;
  stim_one_pkg::line_drive_t drive_q,  drive_d;
  stim_one_pkg::line_drive_t saved_q,  saved_d;
  logic [15:0]               tick_q,   tick_d;
  logic [6:0]                ms_q,     ms_d;
  logic                      done_q,   done_d;
  logic                      run;
  logic                      met;
  logic                      timer_done;
  logic                      apply_now;
  logic [2:0]                sel;
  logic [3:0]                def;
  logic [6:0]                target;

  function automatic logic sel_reserved(input logic [2:0] s);
    return s == stim_one_pkg::SEL_RSV_A || s == stim_one_pkg::SEL_RSV_B;
  endfunction

  function automatic logic def_reserved(input logic [3:0] d);
    return d == stim_one_pkg::DEF_RSV_A || d == stim_one_pkg::DEF_RSV_B ||
           d == stim_one_pkg::DEF_RSV_C;
  endfunction

  function automatic logic [6:0] td_ms(input logic [2:0] c);
    case (c)
      3'h0:    return `TD_CODE0_MS;
      3'h1:    return `TD_CODE1_MS;
      3'h2:    return `TD_CODE2_MS;
      3'h3:    return `TD_CODE3_MS;
      3'h4:    return `TD_CODE4_MS;
      3'h5:    return `TD_CODE5_MS;
      3'h6:    return `TD_CODE6_MS;
      default: return `TD_CODE7_MS;
    endcase
  endfunction

  function automatic logic stim_met(input logic [2:0] s, input stim_one_pkg::stim_inputs_t i);
    case (s)
      stim_one_pkg::SEL_VBUS_PRE:  return i.vbus_ready_pre;
      stim_one_pkg::SEL_DP_ABOVE,
      stim_one_pkg::SEL_DP_ABOVE2: return i.dp_above_th;
      stim_one_pkg::SEL_DP_WINDOW: return !i.dp_above_th && i.dp_above_floor;
      stim_one_pkg::SEL_DM_ABOVE:  return i.dm_above_th;
      stim_one_pkg::SEL_VBUS_POST: return i.vbus_present_post;
      default:                     return 1'b0;
    endcase
  endfunction

  function automatic stim_one_pkg::line_drive_t apply_response(
    input stim_one_pkg::line_drive_t p,
    input logic [3:0]                d,
    input logic [3:0]                m,
    input logic [2:0]                s
  );
    stim_one_pkg::line_drive_t n;
    logic                      keep_pd;
    logic                      dp_hit;
    logic                      dm_hit;
    logic                      volt;
    logic                      res;
    logic                      div;
    n       = p;
    keep_pd = (s == stim_one_pkg::SEL_VBUS_PRE);
    volt    = d inside {stim_one_pkg::DEF_VOLT_DP, stim_one_pkg::DEF_VOLT_DM,
                        stim_one_pkg::DEF_VOLT_ALL};
    res     = d inside {stim_one_pkg::DEF_RES_DP, stim_one_pkg::DEF_RES_DM,
                        stim_one_pkg::DEF_RES_ALL};
    div     = d inside {stim_one_pkg::DEF_DIV_DP, stim_one_pkg::DEF_DIV_DM,
                        stim_one_pkg::DEF_DIV_ALL};
    dp_hit  = d inside {stim_one_pkg::DEF_VOLT_DP, stim_one_pkg::DEF_VOLT_ALL,
                        stim_one_pkg::DEF_RES_DP, stim_one_pkg::DEF_DIV_DP,
                        stim_one_pkg::DEF_DIV_ALL, stim_one_pkg::DEF_RES_ALL};
    dm_hit  = d inside {stim_one_pkg::DEF_VOLT_DM, stim_one_pkg::DEF_VOLT_ALL,
                        stim_one_pkg::DEF_RES_DM, stim_one_pkg::DEF_DIV_DM,
                        stim_one_pkg::DEF_DIV_ALL, stim_one_pkg::DEF_RES_ALL};
    if (d == stim_one_pkg::DEF_CLEAR) begin
      n = '0;
    end else if (d == stim_one_pkg::DEF_PD_A || d == stim_one_pkg::DEF_PD_B) begin
      if (s == stim_one_pkg::SEL_VBUS_POST) begin
        n.dp_pulldown = 1'b0;
        n.dm_pulldown = 1'b0;
      end
    end else begin
      n.magnitude = m;
      n.short_lines = (d == stim_one_pkg::DEF_SHORT) ? 1'b1 : p.short_lines;
      if (dp_hit) begin
        n.dp_volt     = volt;
        n.dp_res      = res;
        n.dp_div      = div;
        n.dp_pulldown = 1'b0;
      end else begin
        n.dp_pulldown = p.dp_pulldown && keep_pd;
      end
      if (dm_hit) begin
        n.dm_volt     = volt;
        n.dm_res      = res;
        n.dm_div      = div;
        n.dm_pulldown = 1'b0;
      end else begin
        n.dm_pulldown = p.dm_pulldown && keep_pd;
      end
    end
    return n;
  endfunction

  assign run    = cfg_q[`CFG_RUN_BIT];
  assign sel    = timing_q[`SEL_MSB:`SEL_LSB];
  assign def    = resp_q[`DEF_MSB:`DEF_LSB];
  assign target = td_ms(timing_q[`TD_MSB:`TD_LSB]);

  // register file
  always_comb begin
    cfg_d    = cfg_q;
    timing_d = timing_q;
    resp_d   = resp_q;
    rdata_d  = rdata_q;
    if (reg_wr) begin
      case (reg_addr)
        `ADDR_EMU_CONFIG: begin
          cfg_d = reg_wdata;
        end
        `ADDR_STIM_TIMING: begin
          timing_d[`TIMING_TYPE_BIT:`TD_LSB] = reg_wdata[`TIMING_TYPE_BIT:`TD_LSB];
          if (!sel_reserved(reg_wdata[`SEL_MSB:`SEL_LSB])) begin
            timing_d[`SEL_MSB:`SEL_LSB] = reg_wdata[`SEL_MSB:`SEL_LSB];
          end
        end
        `ADDR_STIM_RESPONSE: begin
          if (reg_wdata[`MAG_MSB:`MAG_LSB] != `MAG_RESERVED) begin
            resp_d[`MAG_MSB:`MAG_LSB] = reg_wdata[`MAG_MSB:`MAG_LSB];
          end
          if (!def_reserved(reg_wdata[`DEF_MSB:`DEF_LSB])) begin
            resp_d[`DEF_MSB:`DEF_LSB] = reg_wdata[`DEF_MSB:`DEF_LSB];
          end
        end
        default: begin
        end
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        `ADDR_EMU_CONFIG:    rdata_d = cfg_q;
        `ADDR_STIM_TIMING:   rdata_d = {1'b0, timing_q};
        `ADDR_STIM_RESPONSE: rdata_d = resp_q;
        default:             rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_q    <= `RST_EMU_CONFIG;
      timing_q <= `RST_STIM_TIMING;
      resp_q   <= `RST_STIM_RESPONSE;
      rdata_q  <= 8'h00;
    end else begin
      cfg_q    <= cfg_d;
      timing_q <= timing_d;
      resp_q   <= resp_d;
      rdata_q  <= rdata_d;
    end
  end

  // sequencer
  always_comb begin
    state_d    = state_q;
    drive_d    = drive_q;
    saved_d    = saved_q;
    tick_d     = tick_q;
    ms_d       = ms_q;
    done_d     = done_q;
    apply_now  = 1'b0;
    met        = stim_met(sel, stim_in);
    timer_done = (ms_q >= target);
    if (state_q == stim_one_pkg::ST_DELAY || state_q == stim_one_pkg::ST_HOLD) begin
      if (tick_q == 16'(CYC_PER_MS - 1)) begin
        tick_d = 16'h0000;
        if (ms_q != `MS_COUNT_MAX) begin
          ms_d = ms_q + 7'h01;
        end
      end else begin
        tick_d = tick_q + 16'h0001;
      end
    end
    case (state_q)
      stim_one_pkg::ST_IDLE: begin
        if (run) begin
          drive_d             = '0;
          drive_d.dp_pulldown = 1'b1;
          drive_d.dm_pulldown = 1'b1;
          done_d              = 1'b0;
          state_d             = stim_one_pkg::ST_WAIT;
        end
      end
      stim_one_pkg::ST_WAIT: begin
        if (met) begin
          tick_d = 16'h0000;
          ms_d   = 7'h00;
          if (timing_q[`TIMING_TYPE_BIT]) begin
            apply_now = 1'b1;
            saved_d   = drive_q;
            state_d   = stim_one_pkg::ST_HOLD;
          end else begin
            state_d = stim_one_pkg::ST_DELAY;
          end
        end
      end
      stim_one_pkg::ST_DELAY: begin
        if (timer_done) begin
          apply_now = 1'b1;
          state_d   = stim_one_pkg::ST_DONE;
        end
      end
      stim_one_pkg::ST_HOLD: begin
        if (timer_done) begin
          if (!met || sel == stim_one_pkg::SEL_VBUS_PRE ||
              sel == stim_one_pkg::SEL_VBUS_POST) begin
            drive_d = saved_q;
            state_d = stim_one_pkg::ST_DONE;
          end else begin
            state_d = stim_one_pkg::ST_RELEASE;
          end
        end
      end
      stim_one_pkg::ST_RELEASE: begin
        if (!met) begin
          drive_d = saved_q;
          state_d = stim_one_pkg::ST_DONE;
        end
      end
      stim_one_pkg::ST_DONE: begin
        done_d = 1'b1;
      end
      default: begin
        state_d = stim_one_pkg::ST_IDLE;
      end
    endcase
    if (apply_now) begin
      drive_d = apply_response(drive_q, def, resp_q[`MAG_MSB:`MAG_LSB], sel);
    end
    if (!run) begin
      state_d = stim_one_pkg::ST_IDLE;
      drive_d = '0;
      done_d  = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= stim_one_pkg::ST_IDLE;
      drive_q <= '0;
      saved_q <= '0;
      tick_q  <= 16'h0000;
      ms_q    <= 7'h00;
      done_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      drive_q <= drive_d;
      saved_q <= saved_d;
      tick_q  <= tick_d;
      ms_q    <= ms_d;
      done_q  <= done_d;
    end
  end

  assign reg_rdata  = rdata_q;
  assign line_drive = drive_q;
  assign step_done  = done_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_top_bit_zero;
    reg_rd && reg_addr == `ADDR_STIM_TIMING |=> reg_rdata[7] == 1'b0;
  endproperty
  a_top_bit_zero: assert property (p_top_bit_zero) else $error("timing bit 7 read as one");

  property p_reserved_kept;
    reg_wr && reg_addr == `ADDR_STIM_TIMING && sel_reserved(reg_wdata[2:0])
      |=> timing_q[2:0] == $past(timing_q[2:0]);
  endproperty
  a_reserved_kept: assert property (p_reserved_kept) else $error("reserved selection stored");

  property p_hold_immediate;
    state_q == stim_one_pkg::ST_WAIT && met && timing_q[6] && run
      |=> state_q == stim_one_pkg::ST_HOLD;
  endproperty
  a_hold_immediate: assert property (p_hold_immediate) else $error("hold not entered");

  property p_delay_wait;
    state_q == stim_one_pkg::ST_DELAY && !timer_done && run |=> state_q == stim_one_pkg::ST_DELAY;
  endproperty
  a_delay_wait: assert property (p_delay_wait) else $error("delay left early");

  property p_one_ms_code;
    state_q == stim_one_pkg::ST_WAIT && met && !timing_q[6] && timing_q[5:3] == 3'h1 && run
      ##1 (run && $stable(timing_q)) [*2] |-> state_q == stim_one_pkg::ST_DELAY;
  endproperty
  a_one_ms_code: assert property (p_one_ms_code) else $error("1 ms delay ended early");

  property p_window;
    state_q == stim_one_pkg::ST_WAIT && sel == stim_one_pkg::SEL_DP_WINDOW &&
      stim_in.dp_above_th && run |=> state_q == stim_one_pkg::ST_WAIT;
  endproperty
  a_window: assert property (p_window) else $error("window met above threshold");

  property p_clear;
    apply_now && def == stim_one_pkg::DEF_CLEAR && run |=> line_drive == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("clear left a response");

  property p_short;
    apply_now && def == stim_one_pkg::DEF_SHORT && run |=> line_drive.short_lines;
  endproperty
  a_short: assert property (p_short) else $error("short not applied");

  property p_pd_remove;
    apply_now && def == stim_one_pkg::DEF_PD_A && sel == stim_one_pkg::SEL_VBUS_POST && run
      |=> !line_drive.dp_pulldown && !line_drive.dm_pulldown;
  endproperty
  a_pd_remove: assert property (p_pd_remove) else $error("pull-downs not removed");

  property p_done_follows;
    state_q == stim_one_pkg::ST_DONE && run |=> step_done;
  endproperty
  a_done_follows: assert property (p_done_follows) else $error("step done not raised");

  c_delay_path: cover property (state_q == stim_one_pkg::ST_DELAY ##1
                                state_q == stim_one_pkg::ST_DONE);
  c_hold_release: cover property (state_q == stim_one_pkg::ST_RELEASE ##1
                                  state_q == stim_one_pkg::ST_DONE);
  c_reserved_write: cover property (reg_wr && reg_addr == `ADDR_STIM_RESPONSE &&
                                    def_reserved(reg_wdata[3:0]));

endmodule

// ---- core/stim_one_consts.svh ----
`ifndef STIM_ONE_CONSTS_SVH
`define STIM_ONE_CONSTS_SVH

// register offsets
`define ADDR_EMU_CONFIG     8'h40
`define ADDR_STIM_TIMING    8'h41
`define ADDR_STIM_RESPONSE  8'h42

// reset values
`define RST_EMU_CONFIG      8'h00
`define RST_STIM_TIMING     7'h00
`define RST_STIM_RESPONSE   8'h00

// field positions
`define CFG_RUN_BIT         0
`define TIMING_TYPE_BIT     6
`define TD_MSB              5
`define TD_LSB              3
`define SEL_MSB             2
`define SEL_LSB             0
`define MAG_MSB             7
`define MAG_LSB             4
`define DEF_MSB             3
`define DEF_LSB             0
`define MAG_RESERVED        4'hF

// timing
`define CLK_PERIOD_NS       20
`define MS_PERIOD_NS        1000000
`define TD_CODE0_MS         7'h00
`define TD_CODE1_MS         7'h01
`define TD_CODE2_MS         7'h05
`define TD_CODE3_MS         7'h0A
`define TD_CODE4_MS         7'h14
`define TD_CODE5_MS         7'h28
`define TD_CODE6_MS         7'h50
`define TD_CODE7_MS         7'h64
`define MS_COUNT_MAX        7'h7F

`endif

// ---- core/stim_one_pkg.sv ----
package stim_one_pkg;

  typedef enum logic [2:0] {
    SEL_VBUS_PRE  = 3'h0,
    SEL_DP_ABOVE  = 3'h1,
    SEL_DP_WINDOW = 3'h2,
    SEL_DM_ABOVE  = 3'h3,
    SEL_RSV_A     = 3'h4,
    SEL_RSV_B     = 3'h5,
    SEL_DP_ABOVE2 = 3'h6,
    SEL_VBUS_POST = 3'h7
  } stim_sel_t;

  typedef enum logic [3:0] {
    DEF_CLEAR    = 4'h0,
    DEF_VOLT_DP  = 4'h1,
    DEF_VOLT_DM  = 4'h2,
    DEF_VOLT_ALL = 4'h3,
    DEF_RES_DP   = 4'h4,
    DEF_RSV_A    = 4'h5,
    DEF_DIV_DP   = 4'h6,
    DEF_RES_DM   = 4'h7,
    DEF_RSV_B    = 4'h8,
    DEF_DIV_DM   = 4'h9,
    DEF_SHORT    = 4'hA,
    DEF_RSV_C    = 4'hB,
    DEF_DIV_ALL  = 4'hC,
    DEF_RES_ALL  = 4'hD,
    DEF_PD_A     = 4'hE,
    DEF_PD_B     = 4'hF
  } resp_def_t;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_WAIT    = 3'h1,
    ST_DELAY   = 3'h2,
    ST_HOLD    = 3'h3,
    ST_RELEASE = 3'h4,
    ST_DONE    = 3'h5
  } state_t;

  // comparator results from the analog front end
  typedef struct packed {
    logic vbus_ready_pre;
    logic vbus_present_post;
    logic dp_above_th;
    logic dm_above_th;
    logic dp_above_floor;
  } stim_inputs_t;

  // what is connected to the downstream data lines
  typedef struct packed {
    logic       dp_volt;
    logic       dm_volt;
    logic       dp_res;
    logic       dm_res;
    logic       dp_div;
    logic       dm_div;
    logic       short_lines;
    logic       dp_pulldown;
    logic       dm_pulldown;
    logic [3:0] magnitude;
  } line_drive_t;

endpackage
